// file: core/ibpe_pkg.sv
// Purpose: shared constants and types of the two-wire bus master engine
// Assumes: 100 MHz system clock; bus timing of the 100 kHz class
// Notes:   all timing counts derive from ns figures and the clock period
package ibpe_pkg;

   localparam int CLK_PERIOD_NS = 10;

   // bus timing in ns
   localparam int T_LOW_NS    = 4700;
   localparam int T_HIGH_NS   = 4000;
   localparam int T_SU_STA_NS = 4700;
   localparam int T_HD_STA_NS = 4000;
   localparam int T_SU_STO_NS = 4000;
   localparam int T_BUF_NS    = 4700;
   localparam int T_HD_DAT_NS = 300;

   localparam int CNT_W = 10;

   // least times, rounded up to whole cycles; compared against cnt, hence minus one (C_HD_DAT keeps the full count)
   localparam logic [CNT_W-1:0] C_LOW    = CNT_W'((T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);
   localparam logic [CNT_W-1:0] C_HIGH   = CNT_W'((T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);
   localparam logic [CNT_W-1:0] C_SU_STA = CNT_W'((T_SU_STA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);
   localparam logic [CNT_W-1:0] C_HD_STA = CNT_W'((T_HD_STA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);
   localparam logic [CNT_W-1:0] C_SU_STO = CNT_W'((T_SU_STO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);
   localparam logic [CNT_W-1:0] C_BUF    = CNT_W'((T_BUF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);
   localparam logic [CNT_W-1:0] C_HD_DAT = CNT_W'((T_HD_DAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   localparam logic [3:0] BIT_FIRST = 4'h0;
   localparam logic [3:0] BIT_LAST  = 4'h8;
   localparam logic [3:0] BIT_ACK   = 4'h8;
   localparam logic [3:0] HI_PER_BYTE = 4'h9;

   localparam int CMD_FIFO_DEPTH = 16;

   // own slave address, never called while mastering; value arbitrary
   localparam logic [6:0] OWN_SADDR = 7'h3C;

   typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} ibpe_op_t;

   typedef struct packed {
      ibpe_op_t   op;
      logic [7:0] data;    // write byte, or address byte after a start
      logic       ack_en;  // read: drive acknowledge after the byte
   } ibpe_cmd_t;

   typedef struct packed {
      logic [7:0] data;    // byte seen on the bus
      logic       nack;    // acknowledge bit sampled high
      logic       arb_lost;
      logic       err;     // command not legal in the present bus state
   } ibpe_res_t;

   localparam int CMD_W = $bits(ibpe_cmd_t);

endpackage

// file: core/ibpe_master.sv
// Purpose: bus master engine driving a two-wire bus from a queued command stream
// Assumes: scl/sda pins are open drain, resolved outside; lines are asynchronous
// Notes:   command fifo in front; one result per command, held until taken
// Overview of operation
// - lines only pulled low or released; pull-ups make the high level
// - start: sda falls while scl high; a fresh start only when bus idle, a repeated one while we own it
// - first byte after start: seven-bit address plus direction bit
// - addressed slave pulls sda low on the ninth clock
// - sda changes only while scl low, stable through scl high
// - bytes msb first, eight data clocks plus one acknowledge clock
// - transmitter releases sda in acknowledge slot; receiver holds it low
// - unacknowledged address: master may stop or restart
// - master receiver nack ends data; slave then releases sda
// - stop: sda rises while scl high, freeing the bus
// - stop allowed right after a slave acknowledge
// - repeated start allowed without stop, keeping the bus
// - read: roles swap at the acknowledge after the address byte
// - slave may hold scl low after a byte; master waits
// - slave may stretch any low period; master accepts it
`timescale 1ns/1ps
`default_nettype none

module ibpe_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   logic             full;
   logic             empty;

   assign full        = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign empty       = (wr_q == rd_q);
   assign in_ready_o  = !full;
   assign out_valid_o = !empty;
   assign out_data_o  = mem_q[rd_q[AW-1:0]];

   always_ff @(posedge clk_i)
   begin
      if (in_valid_i && !full)
      begin
         mem_q[wr_q[AW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         if (in_valid_i && !full)
            wr_q <= wr_q + 1'b1;
         if (out_ready_i && !empty)
            rd_q <= rd_q + 1'b1;
      end
   end
endmodule // ibpe_fifo

module ibpe_master
   import ibpe_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic cmd_valid_i,
   output logic      cmd_ready_o,
   input  wire ibpe_cmd_t cmd_i,
   output logic      res_valid_o,
   input  wire logic res_ready_i,
   output ibpe_res_t res_o,
   output logic      bus_busy_o,
   input  wire logic scl_i,
   output logic      scl_o,
   output logic      scl_oe_o,
   input  wire logic sda_i,
   output logic      sda_o,
   output logic      sda_oe_o
);
   typedef enum logic [3:0] {
      S_IDLE, S_ST_LOW, S_ST_WAIT, S_ST_SETUP, S_ST_HOLD,
      S_BLOW, S_BWAIT, S_BHIGH,
      S_SP_LOW, S_SP_WAIT, S_SP_SETUP, S_SP_FREE
   } ibpe_state_t;

   ibpe_state_t      st_q, st_d;
   logic [CNT_W-1:0] cnt_q;
   logic [1:0]       scl_sy_q, sda_sy_q;
   logic             sda_p_q;
   logic             scl_s, sda_s;
   logic             busy_q;
   logic             own_q, rd_phase_q, first_q;
   logic             sdo_q;           // 1 = release sda
   logic             scl_drv_q;
   logic [3:0]       bit_q;
   logic [8:0]       sh_q, rx_q;
   ibpe_cmd_t        cur_q;
   logic             res_vld_q;
   ibpe_res_t        res_q;
   logic             f_valid, pop;
   ibpe_cmd_t        f_cmd;
   logic             arb_hit, byte_done, bad_cmd, lines_free;
   logic [3:0]       hi_cnt_q;

   ibpe_fifo #(.WIDTH(CMD_W), .DEPTH(CMD_FIFO_DEPTH)) u_cmd_fifo (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (cmd_valid_i),
      .in_ready_o  (cmd_ready_o),
      .in_data_i   (cmd_i),
      .out_valid_o (f_valid),
      .out_ready_i (pop),
      .out_data_o  (f_cmd)
   );

   // two-flop synchronisers, plus one more stage for edge finding
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         scl_sy_q <= 2'b11;
         sda_sy_q <= 2'b11;
         sda_p_q  <= 1'b1;
      end
      else
      begin
         scl_sy_q <= {scl_sy_q[0], scl_i};
         sda_sy_q <= {sda_sy_q[0], sda_i};
         sda_p_q  <= sda_sy_q[1];
      end
   end
   assign scl_s = scl_sy_q[1];
   assign sda_s = sda_sy_q[1];

   // busy tracking so a fresh start never cuts into a foreign transfer
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         busy_q <= 1'b0;
      else if (scl_s && sda_p_q && !sda_s)
         busy_q <= 1'b1;
      else if (scl_s && !sda_p_q && sda_s)
         busy_q <= 1'b0;
   end
   assign bus_busy_o = busy_q;

   assign lines_free = !busy_q && scl_s && sda_s;
   assign bad_cmd    = ((f_cmd.op == OP_WRITE) && (!own_q || rd_phase_q))
                     || ((f_cmd.op == OP_READ) && (!own_q || !rd_phase_q))
                     || ((f_cmd.op == OP_STOP) && !own_q)
                     || ((f_cmd.op == OP_WRITE) && first_q
                         && (f_cmd.data[7:1] == OWN_SADDR));
   // next command waits while a result is unread: scl stays held low meanwhile only while we own the bus
   assign pop = (st_q == S_IDLE) && f_valid && !res_vld_q
              && (f_cmd.op != OP_START || own_q || lines_free);

   // lost when we release sda in a write bit and the bus reads low
   assign arb_hit = (st_q == S_BHIGH) && sdo_q && !sda_s
                  && (cur_q.op == OP_WRITE) && (bit_q != BIT_ACK);
   assign byte_done = (st_q == S_BHIGH) && !arb_hit && (bit_q == BIT_LAST)
                    && (cnt_q == C_HIGH || !scl_s);

   always_comb
   begin
      st_d = st_q;
      unique case (st_q)
         S_IDLE:
            if (pop && !bad_cmd)
            begin
               unique case (f_cmd.op)
                  OP_START: st_d = own_q ? S_ST_LOW : S_ST_WAIT;
                  OP_STOP:  st_d = S_SP_LOW;
                  default:  st_d = S_BLOW;
               endcase
            end
         S_ST_LOW:   if (cnt_q == C_LOW) st_d = S_ST_WAIT;
         S_ST_WAIT:  if (scl_s && sda_s) st_d = S_ST_SETUP;
         S_ST_SETUP:
            if (!sda_s || !scl_s)
               st_d = S_IDLE;
            else if (cnt_q == C_SU_STA)
               st_d = S_ST_HOLD;
         S_ST_HOLD:  if (cnt_q == C_HD_STA) st_d = S_IDLE;
         S_BLOW:     if (cnt_q == C_LOW) st_d = S_BWAIT;
         S_BWAIT:    if (scl_s) st_d = S_BHIGH;
         S_BHIGH:
            if (arb_hit)
               st_d = S_IDLE;
            else if (cnt_q == C_HIGH || !scl_s)
               st_d = (bit_q == BIT_LAST) ? S_IDLE : S_BLOW;
         S_SP_LOW:   if (cnt_q == C_LOW) st_d = S_SP_WAIT;
         S_SP_WAIT:  if (scl_s) st_d = S_SP_SETUP;
         S_SP_SETUP: if (cnt_q == C_SU_STO) st_d = S_SP_FREE;
         S_SP_FREE:  if (cnt_q == C_BUF) st_d = S_IDLE;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_q  <= S_IDLE;
         cnt_q <= '0;
      end
      else
      begin
         st_q  <= st_d;
         cnt_q <= (st_d != st_q) ? '0 : cnt_q + 1'b1;
      end
   end

   // scl pulled low only in our low phases or while we own the bus idle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         scl_drv_q <= 1'b0;
      else
         scl_drv_q <= (st_q == S_BLOW) || (st_q == S_ST_LOW) || (st_q == S_SP_LOW)
                    || ((st_q == S_IDLE) && own_q);
   end

   // data bits move sda a hold time into a low phase; start and stop move it with scl high
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         sdo_q <= 1'b1;
      else if (arb_hit)
         sdo_q <= 1'b1;
      else if (st_q == S_BLOW && cnt_q == C_HD_DAT)
         sdo_q <= sh_q[4'(BIT_LAST - bit_q)];
      else if (st_q == S_ST_LOW && cnt_q == C_HD_DAT)
         sdo_q <= 1'b1;
      else if (st_q == S_ST_HOLD)
         sdo_q <= 1'b0;
      else if (st_q == S_SP_LOW && cnt_q == C_HD_DAT)
         sdo_q <= 1'b0;
      else if (st_q == S_SP_FREE)
         sdo_q <= 1'b1;
      else if (st_q == S_IDLE && !own_q)
         sdo_q <= 1'b1;
   end

   assign scl_o    = 1'b0;
   assign sda_o    = 1'b0;
   assign scl_oe_o = scl_drv_q;
   assign sda_oe_o = !sdo_q;

   // current command, shift pattern and bit position
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cur_q <= '0;
         sh_q  <= '1;
         bit_q <= BIT_FIRST;
         rx_q  <= '0;
      end
      else
      begin
         if (pop)
         begin
            cur_q <= f_cmd;
            bit_q <= BIT_FIRST;
            // write: byte then released ack slot; read: released byte then our ack
            sh_q  <= (f_cmd.op == OP_READ) ? {8'hFF, !f_cmd.ack_en}
                                           : {f_cmd.data, 1'b1};
         end
         else if (st_q == S_BHIGH && st_d == S_BLOW)
            bit_q <= bit_q + 1'b1;
         if (st_q == S_BWAIT && st_d == S_BHIGH)
            rx_q <= {rx_q[7:0], sda_s};
      end
   end

   // bus ownership and direction
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         own_q      <= 1'b0;
         rd_phase_q <= 1'b0;
         first_q    <= 1'b0;
      end
      else if (arb_hit || (st_q == S_ST_SETUP && st_d == S_IDLE))
      begin
         own_q      <= 1'b0;
         rd_phase_q <= 1'b0;
         first_q    <= 1'b0;
      end
      else if (st_q == S_ST_HOLD && st_d == S_IDLE)
      begin
         own_q      <= 1'b1;
         rd_phase_q <= 1'b0;
         first_q    <= 1'b1;
      end
      else if (st_q == S_SP_FREE && st_d == S_IDLE)
      begin
         own_q   <= 1'b0;
         first_q <= 1'b0;
      end
      else if (byte_done)
      begin
         first_q <= 1'b0;
         // address with read bit acknowledged: we turn receiver
         if (first_q && cur_q.data[0] && !sda_s)
            rd_phase_q <= 1'b1;
      end
   end

   // one result per command; stays until taken
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         res_vld_q <= 1'b0;
         res_q     <= '0;
      end
      else if (res_vld_q)
      begin
         if (res_ready_i)
            res_vld_q <= 1'b0;
      end
      else if (pop && bad_cmd)
      begin
         res_vld_q <= 1'b1;
         res_q     <= '{data: 8'h00, nack: 1'b0, arb_lost: 1'b0, err: 1'b1};
      end
      else if (arb_hit || (st_q == S_ST_SETUP && st_d == S_IDLE))
      begin
         res_vld_q <= 1'b1;
         res_q     <= '{data: 8'h00, nack: 1'b0, arb_lost: 1'b1, err: 1'b0};
      end
      else if (byte_done)
      begin
         res_vld_q <= 1'b1;
         // nack reported, caller may then stop or restart
         // rx_q[0] holds the acknowledge bit, the byte sits above it
         res_q     <= '{data: rx_q[8:1], nack: sda_s, arb_lost: 1'b0, err: 1'b0};
      end
      else if ((st_q == S_ST_HOLD || st_q == S_SP_FREE) && st_d == S_IDLE)
      begin
         res_vld_q <= 1'b1;
         res_q     <= '0;
      end
   end
   assign res_valid_o = res_vld_q;
   assign res_o       = res_q;

   // helper: high phases seen in the current byte
   always_ff @(posedge clk_i)
   begin
      if (rst_i || st_q == S_IDLE)
         hi_cnt_q <= '0;
      else if (st_q == S_BWAIT && st_d == S_BHIGH)
         hi_cnt_q <= hi_cnt_q + 1'b1;
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_stop_tail;
      (st_q == S_SP_SETUP) ##1 (st_q == S_SP_FREE);
   endsequence

   property p_sda_data_change;
      (st_q inside {S_BLOW, S_BWAIT, S_BHIGH}) && $changed(sdo_q) |-> scl_drv_q;
   endproperty
   a_sda_data_change: assert property (p_sda_data_change)
      else $error("sda moved while scl not held low");

   property p_ack_release;
      (st_q == S_BHIGH) && (cur_q.op == OP_WRITE) && (bit_q == BIT_ACK) |-> sdo_q;
   endproperty
   a_ack_release: assert property (p_ack_release)
      else $error("sda driven in write acknowledge slot");

   property p_nine_clocks;
      byte_done |-> (hi_cnt_q == HI_PER_BYTE);
   endproperty
   a_nine_clocks: assert property (p_nine_clocks)
      else $error("byte ended without nine clock pulses");

   property p_high_needs_scl;
      (st_q == S_BHIGH) && !scl_s |=> (st_q != S_BHIGH);
   endproperty
   a_high_needs_scl: assert property (p_high_needs_scl)
      else $error("high phase kept after scl fell");

   property p_wait_released;
      (st_q == S_BWAIT) && $past(st_q == S_BWAIT) |-> !scl_drv_q;
   endproperty
   a_wait_released: assert property (p_wait_released)
      else $error("scl held while waiting for stretch release");

   sequence s_arb;
      arb_hit ##1 1'b1;
   endsequence
   property p_arb_release;
      s_arb |-> sdo_q && !own_q && (st_q == S_IDLE) ##1 !scl_drv_q;
   endproperty
   a_arb_release: assert property (p_arb_release)
      else $error("bus not released after arbitration loss");

   property p_start_shape;
      (st_q == S_ST_HOLD) && (cnt_q == C_HD_DAT) |-> !sdo_q && !scl_drv_q;
   endproperty
   a_start_shape: assert property (p_start_shape)
      else $error("start not sda low with scl released");

   property p_stop_shape;
      s_stop_tail |-> !scl_drv_q ##1 sdo_q;
   endproperty
   a_stop_shape: assert property (p_stop_shape)
      else $error("stop did not release sda with scl high");

   property p_read_turn;
      byte_done && first_q && cur_q.data[0] && !sda_s |=> rd_phase_q;
   endproperty
   a_read_turn: assert property (p_read_turn)
      else $error("no receive phase after acknowledged read address");

   property p_no_own_addr;
      (st_q == S_BLOW) && first_q && (cur_q.op == OP_WRITE) |-> (cur_q.data[7:1] != OWN_SADDR);
   endproperty
   a_no_own_addr: assert property (p_no_own_addr)
      else $error("own slave address sent as master");

endmodule // ibpe_master

`default_nettype wire

// file: tb/ibpe_slave_model.sv
// Purpose: behavioural slave on the two-wire bus for the master engine bench
// Assumes: lines resolved outside with pull-ups; the model only pulls low
// Notes:   arb_i mimics a rival master sending zeros through the address byte
`timescale 1ns/1ps
`default_nettype none

module ibpe_slave_model #(
   parameter logic [6:0] ADDR = 7'h2A
) (
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   input  wire logic        arb_i,
   input  wire logic [15:0] stretch_i,
   input  wire logic [7:0]  rd_i,
   output logic             scl_oe_o,
   output logic             sda_oe_o,
   output logic [7:0]       rx_o
);
   logic [7:0] sh;
   logic [7:0] tx;
   logic [3:0] bitn;
   logic       first;
   logic       sel;
   logic       rd;
   logic       nak;

   initial
   begin
      scl_oe_o = 1'b0;
      sda_oe_o = 1'b0;
      rx_o     = 8'h00;
      bitn     = 4'h0;
      first    = 1'b0;
      sel      = 1'b0;
      rd       = 1'b0;
      nak      = 1'b1;
   end

   always @(negedge sda_i)
      if (scl_i === 1'b1)
      begin
         bitn     = 4'h0;
         first    = 1'b1;
         sel      = 1'b0;
         sda_oe_o = 1'b0;
      end

   always @(posedge sda_i)
      if (scl_i === 1'b1)
      begin
         first    = 1'b0;
         sel      = 1'b0;
         sda_oe_o = 1'b0;
      end

   always @(posedge scl_i)
   begin
      if (bitn < 4'h8)
         sh = {sh[6:0], sda_i};
      else if (bitn == 4'h8)
         nak = sda_i;
      bitn = bitn + 4'h1;
   end

   always @(negedge scl_i)
   begin
      #300;   // data hold after the falling clock
      if (bitn == 4'h8 && first)
      begin
         first    = 1'b0;
         sel      = (sh[7:1] == ADDR);
         rd       = sh[0];
         tx       = rd_i;
         sda_oe_o = sel;
      end
      else if (bitn == 4'h8)
      begin
         if (sel && !rd)
            rx_o = sh;
         if (rd)
            tx = tx + 8'h01;
         sda_oe_o = sel && !rd;
      end
      else if (bitn == 4'h9)
      begin
         bitn     = 4'h0;
         sda_oe_o = sel && rd && !nak && !tx[7];
      end
      else if (sel && rd && !nak)
         sda_oe_o = !tx[7 - bitn];
      else
         sda_oe_o = first && arb_i;
   end

   // longer than the master's low time, so the stretch really shows
   always @(negedge scl_i)
      if (stretch_i != 16'h0000)
      begin
         scl_oe_o = 1'b1;
         #(stretch_i);
         scl_oe_o = 1'b0;
      end

endmodule // ibpe_slave_model

`default_nettype wire

// file: tb/ibpe_master_tb_top.sv
// Purpose: self-checking bench for the two-wire master engine
// Assumes: one slave model on the bus; pull-ups on both lines
// Notes:   results are predicted into a queue and matched as they leave
`timescale 1ns/1ps
`default_nettype none

module ibpe_master_tb_top
   import ibpe_pkg::*;
;
   localparam logic [6:0] SADDR = 7'h2A;
   localparam ibpe_res_t  ALL   = ibpe_res_t'(11'h7FF);
   localparam ibpe_res_t  ERM   = ibpe_res_t'(11'h003);

   logic        clk = 1'b0;
   logic        rst_i, cmd_valid_i, res_ready_i, hold, arb;
   logic        cmd_ready_o, res_valid_o, bus_busy_o;
   logic        scl_o, scl_oe_o, sda_o, sda_oe_o, m_scl_oe, m_sda_oe;
   logic [15:0] stretch;
   logic [7:0]  rdv, wdv, m_rx;
   ibpe_cmd_t   cmd_i;
   ibpe_res_t   res_o;
   ibpe_res_t   exp_q[$];
   ibpe_res_t   msk_q[$];
   wire         scl;
   wire         sda;
   int          error_cnt;
   int          checked;

   // wired-and with pull-ups
   assign scl = (scl_oe_o ? scl_o : 1'b1) & ~m_scl_oe;
   assign sda = (sda_oe_o ? sda_o : 1'b1) & ~m_sda_oe;

   always #5 clk = ~clk;

   ibpe_master uut (
      .clk_i(clk), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
      .cmd_i(cmd_i), .res_valid_o(res_valid_o), .res_ready_i(res_ready_i), .res_o(res_o),
      .bus_busy_o(bus_busy_o), .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
      .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o)
   );

   ibpe_slave_model #(.ADDR(SADDR)) slv (
      .scl_i(scl), .sda_i(sda), .arb_i(arb), .stretch_i(stretch), .rd_i(rdv),
      .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe), .rx_o(m_rx)
   );

   task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
      checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic op(input ibpe_op_t o, input logic [7:0] d, input logic a,
                     input ibpe_res_t e, input ibpe_res_t m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      @(negedge clk);
      cmd_valid_i = 1'b1;
      cmd_i = '{op: o, data: d, ack_en: a};
      while (cmd_ready_o !== 1'b1)
         @(negedge clk);
      @(negedge clk);
      cmd_valid_i = 1'b0;
   endtask

   task automatic wr(input logic [7:0] d, input logic nk);
      op(OP_WRITE, d, 1'b0, '{data: d, nack: nk, arb_lost: 1'b0, err: 1'b0}, ALL);
   endtask

   task automatic rdb(input logic a, input logic [7:0] d);
      op(OP_READ, 8'h00, a, '{data: d, nack: !a, arb_lost: 1'b0, err: 1'b0}, ALL);
   endtask

   task automatic ctl(input ibpe_op_t o);
      op(o, 8'h00, 1'b0, ibpe_res_t'(11'h000), ALL);
   endtask

   // bus free time is covered by the idle tail
   task automatic drain(input string nm);
      for (int i = 0; i < 50000 && exp_q.size() != 0; i++)
         @(negedge clk);
      chk("results left", 11'(exp_q.size()), 11'h000);
      repeat (600) @(negedge clk);
      $display("test %s done", nm);
   endtask

   always @(negedge clk)
      res_ready_i <= !hold && ($urandom % 4 != 0);

   always @(posedge clk)
      if (res_valid_o === 1'b1 && res_ready_i === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk("result count", 11'h001, 11'h000);
         else
         begin
            chk("res_o", res_o & msk_q[0], exp_q[0] & msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
         end
      end

   initial
   begin
      repeat (95000) @(posedge clk);
      error_cnt++;
      $display("watchdog expired");
      end_sim();
   end

   initial
   begin
      int n;
      rst_i       = 1'b1;
      cmd_valid_i = 1'b0;
      res_ready_i = 1'b0;
      hold        = 1'b0;
      arb         = 1'b0;
      stretch     = 16'h0000;
      cmd_i       = '0;
      rdv         = 8'h00;
      error_cnt   = 0;
      checked     = 0;
      void'($urandom(32'hDD38));
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst_i = 1'b0;
      chk("idle", 11'({scl_oe_o, sda_oe_o, bus_busy_o, res_valid_o, cmd_ready_o}), 11'h001);
      wdv = 8'($urandom);
      ctl(OP_START);
      wr({SADDR, 1'b0}, 1'b0);
      wr(wdv, 1'b0);
      drain("write");
      chk("bus_busy_o", 11'(bus_busy_o), 11'h001);
      chk("slave byte", 11'(m_rx), 11'(wdv));
      ctl(OP_STOP);
      drain("stop");
      chk("bus_busy_o", 11'(bus_busy_o), 11'h000);
      stretch = 16'(5000 + $urandom % 1000);
      rdv = 8'($urandom);
      ctl(OP_START);
      wr({SADDR, 1'b0}, 1'b0);
      ctl(OP_START);
      wr({SADDR, 1'b1}, 1'b0);
      rdb(1'b1, rdv);
      rdb(1'b0, rdv + 8'h01);
      ctl(OP_STOP);
      drain("read");
      stretch = 16'h0000;
      ctl(OP_START);
      op(OP_WRITE, {OWN_SADDR, 1'b0}, 1'b0, ibpe_res_t'(11'h001), ERM);
      wr({SADDR ^ 7'h01, 1'b0}, 1'b1);
      ctl(OP_STOP);
      drain("no_ack");
      @(posedge clk);
      hold = 1'b1;
      n = 0;
      while (cmd_ready_o === 1'b1 && n < 40)
      begin
         op(n % 3 == 0 ? OP_WRITE : n % 3 == 1 ? OP_READ : OP_STOP, 8'($urandom), 1'b0,
            ibpe_res_t'(11'h001), ERM);
         n++;
      end
      chk("fifo fill", 11'(n > CMD_FIFO_DEPTH), 11'h001);
      chk("cmd_ready_o", 11'(cmd_ready_o), 11'h000);
      @(posedge clk);
      hold = 1'b0;
      drain("refuse");
      chk("cmd_ready_o", 11'(cmd_ready_o), 11'h001);
      arb = 1'b1;
      ctl(OP_START);
      op(OP_WRITE, {SADDR, 1'b1}, 1'b0, ibpe_res_t'(11'h002), ERM);
      drain("arbitration");
      chk("released", 11'({scl_oe_o, sda_oe_o}), 11'h000);
      end_sim();
   end

endmodule // ibpe_master_tb_top

`default_nettype wire
